// [rtl/gt_consts.vh]
// constants for the general timer block: offsets, fields, reset values
// assumes byte addressing on a 32-bit APB, one register per word
`ifndef GT_CONSTS_VH
`define GT_CONSTS_VH
`define GT_OFS_STD_CTRL 8'h00
`define GT_OFS_STD_CNT  8'h04
`define GT_OFS_STD_PER  8'h08
`define GT_OFS_FLAGS    8'h0c
`define GT_OFS_PAIR_A   8'h10
`define GT_OFS_PAIR_B   8'h30
`define GT_IDX_CTRL_LO  3'h0
`define GT_IDX_CTRL_HI  3'h1
`define GT_IDX_CNT_LO   3'h2
`define GT_IDX_CNT_HI   3'h3
`define GT_IDX_PER_LO   3'h4
`define GT_IDX_PER_HI   3'h5
`define GT_RUN   15
`define GT_SIDL  13
`define GT_GATE  6
`define GT_PS_HI 5
`define GT_PS_LO 4
`define GT_CASC  3
`define GT_SYNC  2
`define GT_CS    1
`define GT_STD_MASK 16'ha076
`define GT_LO_MASK  16'ha07a
`define GT_HI_MASK  16'ha072
`define GT_CTRL_RST 16'h0000
`define GT_CNT_RST  16'h0000
`define GT_PER_RST  16'hffff
`define GT_PS_MAX1   8'h00
`define GT_PS_MAX8   8'h07
`define GT_PS_MAX64  8'h3f
`define GT_PS_MAX256 8'hff
`define GT_FLAG_STD  0
`define GT_FLAG_A_LO 1
`define GT_FLAG_A_HI 2
`define GT_FLAG_B_LO 3
`define GT_FLAG_B_HI 4
`endif

// [rtl/gt_timers.v]
// general timers: one standalone 16-bit timer and two 16/32-bit pairs, APB slave
// assumes pins are synchronous to CLK and CLK is the oscillator clock
// Summary of operation
// - standalone 16-bit timer: plain timer, synchronous or unsynchronised external counter
// - control bit 15 runs or stops the count
// - bit 13 set halts the timer while the device idles
// - gate enable bit 6 only acts with the internal clock
// - bits 5-4 select prescale 1, 8, 64 or 256
// - bit 2 selects external clock synchronisation, ignored on internal clock
// - bit 1 selects external pin rising edges or internal half-rate clock
// - flag on period match or, in gated mode, gate falling edge
// - control write while running clears the prescaler
// - unimplemented control bits ignore writes and read zero
// - timer keeps running through idle unless told to stop
// - each pair is two 16-bit synchronous timers or one 32-bit timer
// - lower control bit 3 cascades the pair into 32 bits
// - in 32-bit mode the upper control is ignored, lower controls all
// - in 32-bit mode the upper flag carries the match
// - upper count holds the high word, lower count the low word
// - upper and lower periods form the 32-bit period; match sets flag
// - converter trigger only on first pair: 32-bit match or upper match
`timescale 1ns/1ps
`include "gt_consts.vh"

module gt_tick #(
  parameter ASYNC_OK = 1
) (
  input  wire        clk,
  input  wire        srst,
  input  wire        idle,
  input  wire [15:0] ctrl,
  input  wire        clr,
  input  wire        pin,
  output wire        tick,
  output wire        gate_fall
);
  reg       div;
  reg       s1;
  reg       s2;
  reg       s3;
  reg       a_prev;
  reg [7:0] pre;
  reg [7:0] pmax;
  wire run     = ctrl[`GT_RUN];
  wire ext_sel = ctrl[`GT_CS];
  wire gated   = ctrl[`GT_GATE] & ~ext_sel;
  wire active  = run & ~(idle & ctrl[`GT_SIDL]);
  wire s_edge  = s2 & ~s3;
  wire a_edge  = pin & ~a_prev;
  wire e_edge  = (ctrl[`GT_SYNC] || ASYNC_OK == 0) ? s_edge : a_edge;
  wire i_edge  = div & (~gated | s2);
  wire src     = ext_sel ? e_edge : i_edge;
  assign tick      = active & src & (pre == pmax) & ~clr;
  assign gate_fall = active & gated & s3 & ~s2;

  always @* begin
    case (ctrl[`GT_PS_HI:`GT_PS_LO])
      2'b00:   pmax = `GT_PS_MAX1;
      2'b01:   pmax = `GT_PS_MAX8;
      2'b10:   pmax = `GT_PS_MAX64;
      default: pmax = `GT_PS_MAX256;
    endcase
  end

  always @(posedge clk) begin
    if (srst) begin
      div    <= 1'b0;
      s1     <= 1'b0;
      s2     <= 1'b0;
      s3     <= 1'b0;
      a_prev <= 1'b0;
      pre    <= 8'h00;
    end else begin
      div    <= ~div;
      s1     <= pin;
      s2     <= s1;
      s3     <= s2;
      a_prev <= pin;
      if (!active || clr)
        pre <= 8'h00;
      else if (src)
        pre <= (pre == pmax) ? 8'h00 : pre + 8'h01;
    end
  end
endmodule // gt_tick

module gt_pair #(
  parameter HAS_TRIG = 1
) (
  input  wire        clk,
  input  wire        srst,
  input  wire        idle,
  input  wire        wr_en,
  input  wire [2:0]  idx,
  input  wire [15:0] wdata,
  output reg  [15:0] rd,
  output wire        hit,
  input  wire        pin_lo,
  input  wire        pin_hi,
  output wire        flag_lo,
  output wire        flag_hi,
  output reg         trig
);
  reg  [15:0] ctrl_lo;
  reg  [15:0] ctrl_hi;
  reg  [15:0] cnt_lo;
  reg  [15:0] cnt_hi;
  reg  [15:0] per_lo;
  reg  [15:0] per_hi;
  reg  [15:0] next_cnt_lo;
  reg  [15:0] next_cnt_hi;
  wire        tick_lo;
  wire        tick_hi;
  wire        gf_lo;
  wire        gf_hi;
  wire casc   = ctrl_lo[`GT_CASC];
  wire wr_clo = wr_en & (idx == `GT_IDX_CTRL_LO);
  wire wr_chi = wr_en & (idx == `GT_IDX_CTRL_HI);
  wire wr_nlo = wr_en & (idx == `GT_IDX_CNT_LO);
  wire wr_nhi = wr_en & (idx == `GT_IDX_CNT_HI);
  wire m32    = ({cnt_hi, cnt_lo} == {per_hi, per_lo});
  wire m_lo   = tick_lo & (cnt_lo == per_lo);
  wire m_hi   = tick_hi & (cnt_hi == per_hi);
  wire m_cas  = tick_lo & m32;
  assign hit     = (idx <= `GT_IDX_PER_HI);
  assign flag_lo = ~casc & (m_lo | gf_lo);
  assign flag_hi = casc ? (m_cas | gf_lo) : (m_hi | gf_hi);

  gt_tick #(.ASYNC_OK(0)) u_lo (
    .clk       (clk),
    .srst      (srst),
    .idle      (idle),
    .ctrl      (ctrl_lo),
    .clr       (wr_clo & ctrl_lo[`GT_RUN]),
    .pin       (pin_lo),
    .tick      (tick_lo),
    .gate_fall (gf_lo)
  );

  // upper unit stays idle in 32-bit mode so its control has no effect
  gt_tick #(.ASYNC_OK(0)) u_hi (
    .clk       (clk),
    .srst      (srst),
    .idle      (idle),
    .ctrl      (casc ? `GT_CTRL_RST : ctrl_hi),
    .clr       (wr_chi & ctrl_hi[`GT_RUN]),
    .pin       (pin_hi),
    .tick      (tick_hi),
    .gate_fall (gf_hi)
  );

  always @* begin
    case (idx)
      `GT_IDX_CTRL_LO: rd = ctrl_lo;
      `GT_IDX_CTRL_HI: rd = ctrl_hi;
      `GT_IDX_CNT_LO:  rd = cnt_lo;
      `GT_IDX_CNT_HI:  rd = cnt_hi;
      `GT_IDX_PER_LO:  rd = per_lo;
      `GT_IDX_PER_HI:  rd = per_hi;
      default:         rd = 16'h0000;
    endcase
  end

  always @(posedge clk) begin
    if (srst) begin
      ctrl_lo <= `GT_CTRL_RST;
      ctrl_hi <= `GT_CTRL_RST;
      per_lo  <= `GT_PER_RST;
      per_hi  <= `GT_PER_RST;
      trig    <= 1'b0;
    end else begin
      if (wr_clo)
        ctrl_lo <= wdata & `GT_LO_MASK;
      if (wr_chi)
        ctrl_hi <= wdata & `GT_HI_MASK;
      if (wr_en && idx == `GT_IDX_PER_LO)
        per_lo <= wdata;
      if (wr_en && idx == `GT_IDX_PER_HI)
        per_hi <= wdata;
      trig <= (HAS_TRIG != 0) & (casc ? m_cas : m_hi);
    end
  end

  // count writes from software win over a tick in the same cycle
  always @* begin
    next_cnt_lo = cnt_lo;
    next_cnt_hi = cnt_hi;
    if (tick_lo) begin
      if (casc ? m32 : (cnt_lo == per_lo))
        next_cnt_lo = 16'h0000;
      else
        next_cnt_lo = cnt_lo + 16'h0001;
    end
    // the 32-bit count has no snapshot: software reads high, low, high
    if (casc && tick_lo) begin
      if (m32)
        next_cnt_hi = 16'h0000;
      else
        next_cnt_hi = cnt_hi + {15'h0000, &cnt_lo};
    end else if (!casc && tick_hi) begin
      if (cnt_hi == per_hi)
        next_cnt_hi = 16'h0000;
      else
        next_cnt_hi = cnt_hi + 16'h0001;
    end
    if (wr_nlo)
      next_cnt_lo = wdata;
    if (wr_nhi)
      next_cnt_hi = wdata;
  end

  always @(posedge clk) begin
    if (srst) begin
      cnt_lo <= `GT_CNT_RST;
      cnt_hi <= `GT_CNT_RST;
    end else begin
      cnt_lo <= next_cnt_lo;
      cnt_hi <= next_cnt_hi;
    end
  end
endmodule // gt_pair

module gt_timers (
  input  wire        CLK,
  input  wire        SRST,
  input  wire        PSEL,
  input  wire        PENABLE,
  input  wire        PWRITE,
  input  wire [7:0]  PADDR,
  input  wire [31:0] PWDATA,
  output wire [31:0] PRDATA,
  output wire        PREADY,
  output wire        PSLVERR,
  input  wire        IDLE,
  input  wire        STANDALONE_EXT_CLOCK_PIN,
  input  wire        PAIR_A_LO_PIN,
  input  wire        PAIR_A_HI_PIN,
  input  wire        PAIR_B_LO_PIN,
  input  wire        PAIR_B_HI_PIN,
  output wire [4:0]  FLAGS,
  output wire        ADC_TRIG
);
  reg  [15:0] std_ctrl;
  reg  [15:0] std_cnt;
  reg  [15:0] std_per;
  reg  [15:0] next_std_cnt;
  reg  [4:0]  flags;
  reg  [31:0] rdata;
  reg  [15:0] rmux;
  reg         hit;
  wire        std_tick;
  wire        std_gf;
  wire [15:0] rd_a;
  wire [15:0] rd_b;
  wire        hit_a;
  wire        hit_b;
  wire        fa_lo;
  wire        fa_hi;
  wire        fb_lo;
  wire        fb_hi;
  wire        in_a  = (PADDR >= `GT_OFS_PAIR_A) && (PADDR < `GT_OFS_PAIR_A + 8'h18);
  wire        in_b  = (PADDR >= `GT_OFS_PAIR_B) && (PADDR < `GT_OFS_PAIR_B + 8'h18);
  wire        al    = (PADDR[1:0] == 2'b00);
  wire [7:0]  off_a = PADDR - `GT_OFS_PAIR_A;
  wire [7:0]  off_b = PADDR - `GT_OFS_PAIR_B;
  wire        wr    = PSEL & PENABLE & PWRITE & hit;
  wire        wr_sc = wr & (PADDR == `GT_OFS_STD_CTRL);
  wire        std_m = std_tick & (std_cnt == std_per);
  wire [4:0]  set_v = {fb_hi, fb_lo, fa_hi, fa_lo, std_m | std_gf};
  wire [4:0]  clr_v = (wr && PADDR == `GT_OFS_FLAGS) ? PWDATA[4:0] : 5'h00;
  assign PREADY  = 1'b1;
  assign PSLVERR = PSEL & PENABLE & ~hit;
  assign PRDATA  = rdata;
  assign FLAGS   = flags;

  gt_tick #(.ASYNC_OK(1)) u_std (
    .clk       (CLK),
    .srst      (SRST),
    .idle      (IDLE),
    .ctrl      (std_ctrl),
    .clr       (wr_sc & std_ctrl[`GT_RUN]),
    .pin       (STANDALONE_EXT_CLOCK_PIN),
    .tick      (std_tick),
    .gate_fall (std_gf)
  );

  gt_pair #(.HAS_TRIG(1)) u_pair_a (
    .clk     (CLK),
    .srst    (SRST),
    .idle    (IDLE),
    .wr_en   (wr & in_a),
    .idx     (off_a[4:2]),
    .wdata   (PWDATA[15:0]),
    .rd      (rd_a),
    .hit     (hit_a),
    .pin_lo  (PAIR_A_LO_PIN),
    .pin_hi  (PAIR_A_HI_PIN),
    .flag_lo (fa_lo),
    .flag_hi (fa_hi),
    .trig    (ADC_TRIG)
  );

  gt_pair #(.HAS_TRIG(0)) u_pair_b (
    .clk     (CLK),
    .srst    (SRST),
    .idle    (IDLE),
    .wr_en   (wr & in_b),
    .idx     (off_b[4:2]),
    .wdata   (PWDATA[15:0]),
    .rd      (rd_b),
    .hit     (hit_b),
    .pin_lo  (PAIR_B_LO_PIN),
    .pin_hi  (PAIR_B_HI_PIN),
    .flag_lo (fb_lo),
    .flag_hi (fb_hi),
    .trig    ()
  );

  always @* begin
    hit  = al;
    rmux = 16'h0000;
    if (in_a) begin
      rmux = rd_a;
      hit  = al & hit_a;
    end else if (in_b) begin
      rmux = rd_b;
      hit  = al & hit_b;
    end else begin
      case (PADDR)
        `GT_OFS_STD_CTRL: rmux = std_ctrl;
        `GT_OFS_STD_CNT:  rmux = std_cnt;
        `GT_OFS_STD_PER:  rmux = std_per;
        `GT_OFS_FLAGS:    rmux = {11'h000, flags};
        default:          hit  = 1'b0;
      endcase
    end
    // refused accesses read as zero
    if (!hit)
      rmux = 16'h0000;
  end

  // a count write from software wins over a tick in the same cycle
  always @* begin
    next_std_cnt = std_cnt;
    if (std_tick)
      next_std_cnt = (std_cnt == std_per) ? 16'h0000 : std_cnt + 16'h0001;
    if (wr && PADDR == `GT_OFS_STD_CNT)
      next_std_cnt = PWDATA[15:0];
  end

  always @(posedge CLK) begin
    if (SRST) begin
      std_ctrl <= `GT_CTRL_RST;
      std_per  <= `GT_PER_RST;
      std_cnt  <= `GT_CNT_RST;
      flags    <= 5'h00;
      rdata    <= 32'h00000000;
    end else begin
      if (wr_sc)
        std_ctrl <= PWDATA[15:0] & `GT_STD_MASK;
      if (wr && PADDR == `GT_OFS_STD_PER)
        std_per <= PWDATA[15:0];
      std_cnt <= next_std_cnt;
      // set wins over a simultaneous clear
      flags <= (flags & ~clr_v) | set_v;
      // read data is latched in the setup cycle, so a count read is one cycle old
      if (PSEL && !PENABLE)
        rdata <= {16'h0000, rmux};
    end
  end
endmodule // gt_timers

// [testbench/gt_pin_model.sv]
// far-side pin model: bursts of external clock edges and a gate level
// assumes go is a one-cycle request; clock pin stays low between bursts
`timescale 1ns/1ps
module gt_pin_model (
  input  wire       clk,
  input  wire       go,
  input  wire [7:0] nedge,
  input  wire       lvl,
  output reg        clk_pin = 1'b0,
  output wire       gate_pin
);
  reg [7:0] left = 8'h00;
  reg [1:0] ph   = 2'h0;
  assign gate_pin = lvl;
  always @(posedge clk) begin
    if (go) begin
      left <= nedge;
      ph <= 2'h0;
    end else if (left != 8'h00) begin
      ph <= ph + 2'h1;
      if (ph == 2'h3) begin
        left <= left - 8'h01;
      end
    end
  end
  // one rising edge every four cycles
  always @(posedge clk) clk_pin <= (left != 8'h00) && ph[1];
endmodule // gt_pin_model

// [testbench/gt_timers_chk.sv]
// checker for the timer block: bus answers, read-zero bits, flags, trigger
// assumes it is bound to gt_timers and sees only its ports
`timescale 1ns/1ps
module gt_chk (
  input wire        CLK,
  input wire        SRST,
  input wire        PSEL,
  input wire        PENABLE,
  input wire        PWRITE,
  input wire [7:0]  PADDR,
  input wire [31:0] PRDATA,
  input wire        PREADY,
  input wire        PSLVERR,
  input wire [4:0]  FLAGS,
  input wire        ADC_TRIG
);
  wire rd_acc = PSEL && PENABLE && !PWRITE;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SRST);
  ready_high_a:
    assert property (PSEL && PENABLE |-> PREADY) else $error("access not ready");
  upper_zero_a:
    assert property (rd_acc |-> PRDATA[31:16] == 16'h0000) else $error("upper half set");
  std_mask_a:
    assert property (rd_acc && PADDR == 8'h00 |-> (PRDATA[15:0] & 16'h5f89) == 16'h0000)
      else $error("standalone control reads unused bit");
  low_mask_a:
    assert property (rd_acc && (PADDR == 8'h10 || PADDR == 8'h30)
      |-> (PRDATA[15:0] & 16'h5f85) == 16'h0000) else $error("lower control unused bit");
  high_mask_a:
    assert property (rd_acc && (PADDR == 8'h14 || PADDR == 8'h34)
      |-> (PRDATA[15:0] & 16'h5f8d) == 16'h0000) else $error("upper control unused bit");
  trig_pulse_a:
    assert property (ADC_TRIG |=> !ADC_TRIG) else $error("trigger longer than a cycle");
  trig_flag_a:
    assert property (ADC_TRIG |-> FLAGS[2]) else $error("trigger without upper flag");
  flag_hold_a:
    assert property (|($past(FLAGS) & ~FLAGS)
      |-> $past(SRST) || $past(PSEL && PENABLE && PWRITE && PADDR == 8'h0c))
      else $error("flag dropped without clear");
  bad_addr_a:
    assert property (PSEL && PENABLE && PADDR[1:0] != 2'b00 |-> PSLVERR)
      else $error("unaligned access not refused");
  good_addr_a:
    assert property (PSEL && PENABLE && PADDR == 8'h0c |-> !PSLVERR)
      else $error("mapped access refused");
endmodule // gt_chk

bind gt_timers gt_chk gt_chk_i (.CLK(CLK), .SRST(SRST), .PSEL(PSEL), .PENABLE(PENABLE),
  .PWRITE(PWRITE), .PADDR(PADDR), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .FLAGS(FLAGS), .ADC_TRIG(ADC_TRIG));

// [testbench/test_general_timers_16_32bit.sv]
// bench for the timer block: bus tasks, hand-written scenarios, verdict
// assumes the pin model drives every timer pin and the checker is bound
`timescale 1ns/1ps
module test_general_timers_16_32bit;
  logic        CLK = 0, SRST = 1, PSEL = 0, PENABLE = 0, PWRITE = 0, IDLE = 0;
  logic [7:0]  PADDR = 0, ne = 0;
  logic [31:0] PWDATA = 0, rd, c;
  logic        go = 0, lvl = 0, er;
  wire  [31:0] PRDATA;
  wire  [4:0]  FLAGS;
  wire         PREADY, PSLVERR, ADC_TRIG, ck, gt;
  int          fail_count = 0, check_count = 0, trigs = 0, i, s;
  int          pn[4] = '{1, 8, 64, 256};
  gt_timers gt_timers_i (.CLK(CLK), .SRST(SRST), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .IDLE(IDLE), .STANDALONE_EXT_CLOCK_PIN(ck), .PAIR_A_LO_PIN(gt),
    .PAIR_A_HI_PIN(ck), .PAIR_B_LO_PIN(gt), .PAIR_B_HI_PIN(ck), .FLAGS(FLAGS),
    .ADC_TRIG(ADC_TRIG));
  gt_pin_model gt_pin_model_i (.clk(CLK), .go(go), .nedge(ne), .lvl(lvl), .clk_pin(ck),
    .gate_pin(gt));
  initial forever #5 CLK = ~CLK;
  always @(posedge CLK) if (ADC_TRIG === 1'b1) trigs <= trigs + 1;
  task automatic conclude;
    if (fail_count == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] v, input logic [31:0] e);
    check_count++;
    if (v !== e) begin
      $display("CHECK FAILED %s expected %h seen %h", n, e, v);
      fail_count++;
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [15:0] d);
    PSEL <= 1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= {16'h0000, d};
    @(posedge CLK) PENABLE <= 1;
    @(posedge CLK);
    while (PREADY !== 1'b1) @(posedge CLK);
    rd = PRDATA;
    er = PSLVERR;
    PSEL <= 0;
    PENABLE <= 0;
    @(posedge CLK);
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic pulse(input logic [7:0] n);
    ne <= n;
    go <= 1;
    @(posedge CLK) go <= 0;
    repeat (4 * n + 8) @(posedge CLK);
  endtask
  task automatic regs;
    logic [7:0]  ca[3] = '{8'h00, 8'h10, 8'h14};
    logic [15:0] cm[3] = '{16'ha076, 16'ha07a, 16'ha072};
    apb(0, 8'h08, 0);
    chk("period reset", rd, 32'h0000ffff);
    apb(0, 8'h80, 0);
    chk("unmapped error", er, 1);
    chk("unmapped data", rd, 0);
    for (i = 0; i < 3; i++) begin
      apb(0, ca[i], 0);
      chk("control reset", rd, 0);
      wr(ca[i], 16'hffff);
      apb(0, ca[i], 0);
      chk("control bits", rd, {16'h0000, cm[i]});
      wr(ca[i], 0);
    end
  endtask
  task automatic prescale;
    wr(8'h08, 0);
    for (i = 0; i < 4; i++) begin
      wr(8'h0c, 16'h001f);
      wr(8'h00, 16'h8000 | 16'(i << 4));
      if (pn[i] > 1) begin
        repeat (2 * pn[i] - 4) @(posedge CLK);
        chk("early flag", FLAGS[0], 0);
      end
      repeat (14) @(posedge CLK);
      chk("period flag", FLAGS[0], 1);
      wr(8'h00, 0);
    end
  endtask
  task automatic idle_run;
    IDLE <= 1;
    wr(8'h0c, 16'h001f);
    wr(8'h00, 16'ha000);
    repeat (20) @(posedge CLK);
    chk("idle halt", FLAGS[0], 0);
    wr(8'h00, 16'h8000);
    repeat (10) @(posedge CLK);
    chk("idle count", FLAGS[0], 1);
    wr(8'h00, 0);
    IDLE <= 0;
  endtask
  task automatic ext_count;
    for (s = 0; s < 2; s++) begin
      wr(8'h04, 0);
      wr(8'h08, 16'h0004);
      wr(8'h0c, 16'h001f);
      wr(8'h00, 16'h8042 | 16'(s << 2));
      pulse(4);
      apb(0, 8'h04, 0);
      chk("edge count", rd, 4);
      chk("no flag yet", FLAGS[0], 0);
      pulse(1);
      chk("wrap flag", FLAGS[0], 1);
      wr(8'h00, 0);
    end
  endtask
  task automatic cascade;
    wr(8'h18, 16'hfffe);
    wr(8'h14, 16'h0030);
    wr(8'h0c, 16'h001f);
    wr(8'h10, 16'h8008);
    repeat (6) @(posedge CLK);
    wr(8'h10, 16'h0008);
    apb(0, 8'h12, 0);
    chk("unaligned error", er, 1);
    chk("unaligned data", rd, 0);
    apb(0, 8'h1c, 0);
    chk("high word", rd, 1);
    chk("no low match", FLAGS[1], 0);
    wr(8'h18, 16'hfffe);
    wr(8'h1c, 0);
    wr(8'h20, 0);
    wr(8'h24, 16'h0001);
    c = trigs;
    wr(8'h10, 16'h8008);
    repeat (20) @(posedge CLK);
    wr(8'h10, 16'h0008);
    chk("upper flag", FLAGS[2], 1);
    chk("lower flag", FLAGS[1], 0);
    chk("trigger", trigs - c, 1);
    wr(8'h10, 0);
  endtask
  task automatic gated;
    wr(8'h0c, 16'h001f);
    wr(8'h30, 16'h8040);
    lvl <= 1;
    repeat (20) @(posedge CLK);
    lvl <= 0;
    repeat (8) @(posedge CLK);
    chk("gate fall flag", FLAGS[3], 1);
    apb(0, 8'h38, 0);
    c = rd;
    chk("gated advance", c !== 0, 1);
    repeat (10) @(posedge CLK);
    apb(0, 8'h38, 0);
    chk("gated hold", rd, c);
    wr(8'h30, 0);
  endtask
  task automatic rewrite;
    wr(8'h08, 0);
    wr(8'h04, 0);
    wr(8'h0c, 16'h001f);
    wr(8'h00, 16'h8010);
    repeat (10) wr(8'h00, 16'h8010);
    chk("rewrite clears prescale", FLAGS[0], 0);
    repeat (20) @(posedge CLK);
    chk("prescale resumes", FLAGS[0], 1);
    wr(8'h00, 0);
  endtask
  task automatic pair16;
    wr(8'h0c, 16'h001f);
    wr(8'h1c, 0);
    wr(8'h24, 16'h0001);
    wr(8'h3c, 0);
    wr(8'h44, 16'h0001);
    wr(8'h14, 16'h8002);
    wr(8'h34, 16'h8002);
    c = trigs;
    pulse(2);
    chk("upper match", FLAGS[2], 1);
    chk("pair b upper", FLAGS[4], 1);
    chk("idle lower", FLAGS[1], 0);
    chk("upper trigger", trigs - c, 1);
    wr(8'h14, 0);
    wr(8'h34, 0);
  endtask
  initial begin
    repeat (10) @(posedge CLK);
    SRST <= 0;
    regs;
    prescale;
    idle_run;
    rewrite;
    ext_count;
    cascade;
    gated;
    pair16;
    conclude;
  end
  initial begin
    repeat (20000) @(posedge CLK);
    fail_count++;
    conclude;
  end
endmodule // test_general_timers_16_32bit
